// >>> core/mpp_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef MPP_DEFINES_SVH
`define MPP_DEFINES_SVH
`define MPP_CLK_HZ     40000000
`define MPP_BAUD_HZ    115200
`define MPP_PIN_MIN_NS 50000
`define MPP_PIN_MIN_CYC ((`MPP_PIN_MIN_NS*(`MPP_CLK_HZ/1000000)+999)/1000)
`define MPP_OFF_CTRL   8'h00
`define MPP_OFF_REDUCE 8'h04
`define MPP_OFF_HOLD   8'h08
`define MPP_OFF_SMASK  8'h0c
`define MPP_OFF_BAUD   8'h10
`define MPP_OFF_ASEL   8'h14
`define MPP_OFF_ASTART 8'h18
`define MPP_OFF_AEND   8'h1c
`define MPP_OFF_RANGE  8'h20
`define MPP_OFF_MCTRL  8'h24
`define MPP_OFF_MVAL   8'h28
`define MPP_OFF_CMD    8'h2c
`define MPP_OFF_SCFG   8'h30
`define MPP_OFF_STATUS 8'h34
`define MPP_OFF_SRES   8'h40
`define MPP_CTRL_MODE  0
`define MPP_CTRL_TWO   2
`define MPP_CTRL_RSER  3
`define MPP_CTRL_RANA  4
`define MPP_CTRL_ARNG  5
`define MPP_CMD_SET    0
`define MPP_CMD_CLR    1
`define MPP_CMD_ALL    2
`define MPP_CMD_SRST   3
`define MPP_CMD_SIDX   4
`define MPP_CMD_SALL   6
`define MPP_ST_REF     16
`define MPP_ST_RERR    17
`define MPP_ST_OK      18
`define MPP_MC_SRC     8
`define MPP_MC_PIN     16
`define MPP_RST_REDUCE 22'h000001
`define MPP_RST_RANGE  32'h000f4240
`define MPP_RED_MAX    22'h2dc6c0
`define MPP_HOLD_MAX   11'h400
`define MPP_MST_MAX    32'h7ff89ec0
`define MPP_MST_MIN    32'h80076140
`define MPP_SLEN_MAX   4'hd
`define MPP_SER_ERR    18'h3ffff
`define MPP_SER_TOP    18'h3fffe
`define MPP_ANA_ERR    16'h0000
`define MPP_ANA_FULL   16'hffff
`endif

// >>> core/mpp_pkg.sv
// shared types of the measurement post-processing block
package mpp_pkg;
	typedef enum logic [1:0] {
		MPP_ERR_OUT  = 2'h0,
		MPP_HOLD_INF = 2'h1,
		MPP_HOLD_CNT = 2'h2
	} mpp_err_mode_type;
	typedef enum logic [1:0] {MPP_SQ_IDLE = 2'b01, MPP_SQ_SEND = 2'b10}
		mpp_sq_state_type;
	typedef enum logic [1:0] {MPP_TX_IDLE = 2'b01, MPP_TX_SHIFT = 2'b10}
		mpp_tx_state_type;
	typedef enum logic [1:0] {MPP_DV_IDLE = 2'b01, MPP_DV_RUN = 2'b10}
		mpp_dv_state_type;
endpackage

// >>> core/mpp_uart_tx.sv
// 8N1 serial byte transmitter with programmable bit divider
`timescale 1ns/1ps
`include "mpp_defines.svh"
module mpp_uart_tx import mpp_pkg::*; (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic [15:0] baud_div,
	input  wire logic        tx_go,
	input  wire logic [7:0]  tx_byte,
	output logic             tx_rdy,
	output logic             txd
);
	typedef struct packed {
		mpp_tx_state_type st;
		logic [9:0]       sh;
		logic [3:0]       bits;
		logic [15:0]      div;
		logic             txd;
	} mpp_tx_type;
	mpp_tx_type s, n;
	assign tx_rdy = (s.st == MPP_TX_IDLE);
	assign txd = s.txd;
	// frame: start bit, eight data bits lsb first, one stop bit
	always_comb begin
		n = s;
		case (s.st)
			MPP_TX_IDLE: if (tx_go) begin
				n.sh = {1'b1, tx_byte, 1'b0};
				n.bits = 4'h0;
				n.div = 16'h0;
				n.txd = 1'b0;
				n.st = MPP_TX_SHIFT;
			end
			MPP_TX_SHIFT: if (s.div + 16'h1 >= baud_div) begin
				n.div = 16'h0;
				n.sh = {1'b1, s.sh[9:1]};
				n.txd = s.sh[1];
				n.bits = s.bits + 4'h1;
				if (s.bits == 4'h9) begin
					n.txd = 1'b1;
					n.st = MPP_TX_IDLE;
				end
			end else begin
				n.div = s.div + 16'h1;
			end
			default: n.st = MPP_TX_IDLE;
		endcase
	end
	// state register, line idles high
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.st <= MPP_TX_IDLE;
			s.txd <= 1'b1;
		end else begin
			s <= n;
		end
	end
endmodule

// >>> core/mpp_divider.sv
// sequential unsigned divider for analog scaling, 16-bit quotient
`timescale 1ns/1ps
module mpp_divider import mpp_pkg::*; (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        div_go,
	input  wire logic [47:0] div_num,
	input  wire logic [31:0] div_den,
	output logic             div_busy,
	output logic             div_done,
	output logic [15:0]      div_quo
);
	typedef struct packed {
		mpp_dv_state_type st;
		logic [47:0]      q;
		logic [32:0]      rem;
		logic [31:0]      den;
		logic [5:0]       step;
		logic             done;
	} mpp_dv_type;
	mpp_dv_type s, n;
	logic [32:0] trial;
	assign div_busy = (s.st == MPP_DV_RUN);
	assign div_done = s.done;
	assign div_quo = s.q[15:0];
	// one quotient bit per clock, 48 clocks per division
	always_comb begin
		n = s;
		n.done = 1'b0;
		trial = {s.rem[31:0], s.q[47]};
		case (s.st)
			MPP_DV_IDLE: if (div_go) begin
				n.q = div_num;
				n.den = div_den;
				n.rem = 33'h0;
				n.step = 6'h0;
				n.st = MPP_DV_RUN;
			end
			MPP_DV_RUN: begin
				n.q = {s.q[46:0], trial >= {1'b0, s.den}};
				n.rem = (trial >= {1'b0, s.den}) ?
					trial - {1'b0, s.den} : trial;
				n.step = s.step + 6'h1;
				if (s.step == 6'h2f) begin
					n.done = 1'b1;
					n.st = MPP_DV_IDLE;
				end
			end
			default: n.st = MPP_DV_IDLE;
		endcase
	end
	// state register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.st <= MPP_DV_IDLE;
		end else begin
			s <= n;
		end
	end
endmodule

// >>> core/mpp_post_proc.sv
// measurement post-processing: master, stats, reduction, outputs
`timescale 1ns/1ps
`include "mpp_defines.svh"
module mpp_post_proc import mpp_pkg::*; #(
	parameter int NSRC  = 4,
	parameter int NMST  = 10,
	parameter int NSTAT = 3
) (
	input  wire logic               sys_clk,
	input  wire logic               resetn,
	input  wire logic [7:0]         paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               sample_strobe,
	input  wire logic [NSRC*32-1:0] sample_data,
	input  wire logic               sample_ok,
	input  wire logic [1:0]         multifunction_input,
	output logic                    ser_txd,
	output logic [15:0]             ana_code,
	output logic [1:0]              ana_range
);
	localparam int SW = $clog2(NSRC);
	localparam logic [11:0] PIN_MIN = 12'(`MPP_PIN_MIN_CYC);
	typedef struct packed {
		logic [6:0]                    ctrl;
		logic [21:0]                   red_n;
		logic [10:0]                   hold_n;
		logic [NSRC-1:0]               ser_mask;
		logic [15:0]                   baud;
		logic [SW-1:0]                 ana_sel;
		logic [31:0]                   a_start;
		logic [31:0]                   a_end;
		logic [31:0]                   range;
		logic [3:0]                    m_idx;
		logic [NMST-1:0]               pin_mask;
		logic [NMST-1:0][SW-1:0]       m_src;
		logic [NMST-1:0][31:0]         m_val;
		logic [NMST-1:0][31:0]         m_off;
		logic [NMST-1:0]               m_on;
		logic [NSTAT-1:0][SW-1:0]      st_src;
		logic [NSTAT-1:0][3:0]         st_len;
		logic [NSTAT-1:0][13:0]        st_cnt;
		logic [NSTAT-1:0][31:0]        st_min;
		logic [NSTAT-1:0][31:0]        st_max;
		logic [NSTAT-1:0]              st_empty;
		logic [NSRC-1:0][31:0]         last;
		logic                          last_ok;
		logic [10:0]                   held;
		logic [21:0]                   red_cnt;
		logic [NSRC-1:0][17:0]         words;
		mpp_sq_state_type              sq;
		logic [SW-1:0]                 w_idx;
		logic [1:0]                    b_idx;
		logic [1:0]                    pin_s1;
		logic [1:0]                    pin_s2;
		logic [1:0][11:0]              pin_cnt;
		logic [15:0]                   ana;
		logic                          div_go;
		logic [47:0]                   div_num;
		logic [31:0]                   div_den;
		logic [31:0]                   rdata;
		logic                          refused;
		logic                          range_err;
	} mpp_main_type;
	mpp_main_type s, n;
	logic [NSRC-1:0][31:0]  cur, cor;
	logic [NMST-1:0]        set_m, clr_m, sel_m;
	logic [NSTAT-1:0]       st_rst, sel_s;
	logic [1:0]             fire;
	logic                   bad, err, red_hit, do_ser, do_ana, wr;
	logic                   tx_go, tx_rdy, div_busy, div_done;
	logic [15:0]            div_quo;
	logic [31:0]            v;
	logic [32:0]            rd_res;
	logic signed [32:0]     an, ad;
	mpp_err_mode_type       mode;
	////////////////////////////////////////////////////////////////////
	// sum of offsets of active masters attached to one source
	function automatic logic [31:0] off_sum(input mpp_main_type st,
		input int i);
		logic [31:0] acc;
		acc = 32'h0;
		for (int e = 0; e < NMST; e++) begin
			if (st.m_on[e] && st.m_src[e] == SW'(i))
				acc = acc + st.m_off[e];
		end
		return acc;
	endfunction
	// clamp a value into the 18-bit serial code space
	function automatic logic [17:0] sat18(input logic [31:0] x);
		if (x[31])
			return 18'h0;
		else if (x > 32'(`MPP_SER_TOP))
			return `MPP_SER_TOP;
		else
			return x[17:0];
	endfunction
	// stat result index decode: which signal and which quantity
	function automatic logic [31:0] st_rd(input mpp_main_type st,
		input logic [7:0] a, output logic hit);
		logic [31:0] r;
		r = 32'h0;
		hit = 1'b0;
		for (int k = 0; k < NSTAT; k++) begin
			if (a == `MPP_OFF_SRES + 8'(12*k)) begin
				r = st.st_min[k];
				hit = 1'b1;
			end
			if (a == `MPP_OFF_SRES + 8'(12*k+4)) begin
				r = st.st_max[k];
				hit = 1'b1;
			end
			if (a == `MPP_OFF_SRES + 8'(12*k+8)) begin
				r = st.st_max[k] - st.st_min[k];
				hit = 1'b1;
			end
		end
		return r;
	endfunction
	// register read mux, shared by read data and error decode
	function automatic logic [32:0] rd_mux(input mpp_main_type st,
		input logic [7:0] a);
		logic [31:0] r;
		logic hit;
		r = st_rd(st, a, hit);
		case (a)
			`MPP_OFF_CTRL: r = 32'(st.ctrl);
			`MPP_OFF_REDUCE: r = 32'(st.red_n);
			`MPP_OFF_HOLD: r = 32'(st.hold_n);
			`MPP_OFF_SMASK: r = 32'(st.ser_mask);
			`MPP_OFF_BAUD: r = 32'(st.baud);
			`MPP_OFF_ASEL: r = 32'(st.ana_sel);
			`MPP_OFF_ASTART: r = st.a_start;
			`MPP_OFF_AEND: r = st.a_end;
			`MPP_OFF_RANGE: r = st.range;
			`MPP_OFF_MCTRL: r = 32'(st.m_idx) |
				(32'(st.m_src[st.m_idx]) << `MPP_MC_SRC) |
				(32'(st.pin_mask) << `MPP_MC_PIN);
			`MPP_OFF_MVAL: r = st.m_val[st.m_idx];
			`MPP_OFF_CMD: r = 32'h0;
			`MPP_OFF_SCFG: for (int k = 0; k < NSTAT; k++)
				r[k*8+:8] = {2'(st.st_src[k]), 2'h0, st.st_len[k]};
			`MPP_OFF_STATUS: r = 32'(st.m_on) |
				(32'(st.refused) << `MPP_ST_REF) |
				(32'(st.range_err) << `MPP_ST_RERR) |
				(32'(st.last_ok) << `MPP_ST_OK);
			default: if (!hit) return {1'b1, 32'h0};
		endcase
		return {1'b0, r};
	endfunction
	////////////////////////////////////////////////////////////////////
	// apb slave answers in the access cycle, no wait states
	assign pready = 1'b1;
	// decoded read word, bit 32 flags an unmapped address
	assign rd_res = rd_mux(s, paddr);
	assign pslverr = psel && penable && rd_res[32];
	assign prdata = s.rdata;
	assign ana_code = s.ana;
	assign ana_range = s.ctrl[`MPP_CTRL_ARNG+:2];
	assign wr = psel && penable && pwrite;
	// serial word bytes: two tag bits over six code bits
	assign tx_go = (s.sq == MPP_SQ_SEND) && s.ser_mask[s.w_idx] &&
		tx_rdy;
	mpp_uart_tx u_tx (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.baud_div (s.baud),
		.tx_go    (tx_go),
		.tx_byte  ({s.b_idx, s.words[s.w_idx][s.b_idx*6+:6]}),
		.tx_rdy   (tx_rdy),
		.txd      (ser_txd)
	);
	mpp_divider u_div (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.div_go   (s.div_go),
		.div_num  (s.div_num),
		.div_den  (s.div_den),
		.div_busy (div_busy),
		.div_done (div_done),
		.div_quo  (div_quo)
	);
	////////////////////////////////////////////////////////////////////
	// next-state logic of the whole block
	always_comb begin
		n = s;
		n.div_go = 1'b0;
		n.pin_s1 = multifunction_input;
		n.pin_s2 = s.pin_s1;
		mode = mpp_err_mode_type'(s.ctrl[`MPP_CTRL_MODE+:2]);
		bad = !sample_ok;
		// error decision before any offset or statistic
		case (mode)
			MPP_ERR_OUT: err = bad;
			MPP_HOLD_CNT: err = bad && s.hold_n != 11'h0 &&
				s.held >= s.hold_n;
			default: err = 1'b0;
		endcase
		for (int i = 0; i < NSRC; i++) begin
			cur[i] = bad ? s.last[i] : sample_data[i*32+:32];
			cor[i] = cur[i] + off_sum(s, i);
		end
		red_hit = (s.red_cnt + 22'h1 >= s.red_n);
		do_ser = sample_strobe && (!s.ctrl[`MPP_CTRL_RSER] ||
			red_hit);
		do_ana = sample_strobe && (!s.ctrl[`MPP_CTRL_RANA] ||
			red_hit);
		set_m = '0;
		clr_m = '0;
		st_rst = '0;
		sel_m = s.m_idx < 4'(NMST) ? NMST'(1) << s.m_idx : '0;
		sel_s = NSTAT'(1) << pwdata[`MPP_CMD_SIDX+:2];
		v = cor[s.ana_sel];
		an = 33'sh0;
		ad = 33'sh0;
		// pin pulse counted after sync, fires once at least time
		for (int j = 0; j < 2; j++) begin
			fire[j] = s.pin_s2[j] && s.pin_cnt[j] == PIN_MIN - 12'h1;
			if (!s.pin_s2[j])
				n.pin_cnt[j] = 12'h0;
			else if (s.pin_cnt[j] != PIN_MIN)
				n.pin_cnt[j] = s.pin_cnt[j] + 12'h1;
		end
		if (fire[0])
			set_m = s.pin_mask;
		if (fire[1])
			clr_m = s.pin_mask;
		// read data captured in the setup cycle
		if (psel && !penable && !pwrite)
			n.rdata = rd_res[31:0];
		// register writes
		if (wr) begin
			case (paddr)
				`MPP_OFF_CTRL: n.ctrl = pwdata[6:0];
				`MPP_OFF_REDUCE: n.red_n = (pwdata > 32'(`MPP_RED_MAX)) ?
					`MPP_RED_MAX : (pwdata[21:0] == 22'h0) ?
					22'h1 : pwdata[21:0];
				`MPP_OFF_HOLD: n.hold_n = (pwdata > 32'(`MPP_HOLD_MAX))
					? `MPP_HOLD_MAX : pwdata[10:0];
				`MPP_OFF_SMASK: n.ser_mask = pwdata[NSRC-1:0];
				`MPP_OFF_BAUD: n.baud = (pwdata[15:0] == 16'h0) ?
					16'h1 : pwdata[15:0];
				`MPP_OFF_ASEL: n.ana_sel = pwdata[SW-1:0];
				`MPP_OFF_ASTART: n.a_start = pwdata;
				`MPP_OFF_AEND: n.a_end = pwdata;
				`MPP_OFF_RANGE: n.range = pwdata;
				`MPP_OFF_MCTRL: begin
					n.m_idx = pwdata[3:0];
					n.pin_mask = pwdata[`MPP_MC_PIN+:NMST];
					if (pwdata[3:0] < 4'(NMST))
						n.m_src[pwdata[3:0]] =
							pwdata[`MPP_MC_SRC+:SW];
				end
				`MPP_OFF_MVAL: if ($signed(pwdata) >
					$signed(`MPP_MST_MAX) || $signed(pwdata) <
					$signed(`MPP_MST_MIN))
					n.range_err = 1'b1;
				else if (s.m_idx < 4'(NMST))
					n.m_val[s.m_idx] = pwdata;
				`MPP_OFF_CMD: begin
					if (pwdata[`MPP_CMD_ALL])
						sel_m = '1;
					if (pwdata[`MPP_CMD_SET])
						set_m = set_m | sel_m;
					if (pwdata[`MPP_CMD_CLR])
						clr_m = clr_m | sel_m;
					if (pwdata[`MPP_CMD_SALL])
						st_rst = '1;
					else if (pwdata[`MPP_CMD_SRST])
						st_rst = sel_s;
				end
				`MPP_OFF_SCFG: for (int k = 0; k < NSTAT; k++) begin
					n.st_src[k] = pwdata[k*8+6+:SW];
					n.st_len[k] = (pwdata[k*8+:4] > `MPP_SLEN_MAX) ?
						`MPP_SLEN_MAX : pwdata[k*8+:4];
				end
				`MPP_OFF_STATUS: begin
					if (pwdata[`MPP_ST_REF])
						n.refused = 1'b0;
					if (pwdata[`MPP_ST_RERR])
						n.range_err = 1'b0;
				end
				default: n.ctrl = s.ctrl;
			endcase
		end
		// finished division first, so a newer code or error wins
		if (div_done)
			n.ana = div_quo;
		// per-sample bookkeeping, statistics and output dispatch
		if (sample_strobe) begin
			n.last_ok = sample_ok;
			if (!bad) begin
				n.last = sample_data;
				n.held = 11'h0;
			end else if (s.held != 11'h7ff) begin
				n.held = s.held + 11'h1;
			end
			n.red_cnt = red_hit ? 22'h0 : s.red_cnt + 22'h1;
			for (int k = 0; k < NSTAT; k++) begin
				if (!err && (s.st_empty[k] || (s.st_len[k] != 4'h0 &&
					s.st_cnt[k] == 14'h1 << s.st_len[k]))) begin
					n.st_min[k] = cor[s.st_src[k]];
					n.st_max[k] = cor[s.st_src[k]];
					n.st_cnt[k] = 14'h1;
					n.st_empty[k] = 1'b0;
				end else if (!err) begin
					if ($signed(cor[s.st_src[k]]) < $signed(s.st_min[k]))
						n.st_min[k] = cor[s.st_src[k]];
					if ($signed(cor[s.st_src[k]]) > $signed(s.st_max[k]))
						n.st_max[k] = cor[s.st_src[k]];
					if (s.st_cnt[k] != 14'h3fff)
						n.st_cnt[k] = s.st_cnt[k] + 14'h1;
				end
			end
			if (do_ser && s.sq == MPP_SQ_IDLE) begin
				for (int i = 0; i < NSRC; i++)
					n.words[i] = err ? `MPP_SER_ERR : sat18(cor[i]);
				n.w_idx = '0;
				n.b_idx = 2'h0;
				n.sq = MPP_SQ_SEND;
			end
			if (do_ana && err) begin
				n.ana = `MPP_ANA_ERR;
			end else if (do_ana && !div_busy && !s.div_go) begin
				if (s.ctrl[`MPP_CTRL_TWO]) begin
					an = $signed({v[31], v}) -
						$signed({s.a_start[31], s.a_start});
					ad = $signed({s.a_end[31], s.a_end}) -
						$signed({s.a_start[31], s.a_start});
				end else begin
					an = $signed({v[31], v});
					ad = $signed({s.range[31], s.range});
				end
				if (ad < 33'sh0) begin
					an = -an;
					ad = -ad;
				end
				if (an <= 33'sh0 || ad == 33'sh0)
					n.ana = 16'h0;
				else if (an >= ad)
					n.ana = `MPP_ANA_FULL;
				else begin
					n.div_go = 1'b1;
					n.div_num = 48'(an[31:0]) * 48'(`MPP_ANA_FULL);
					n.div_den = ad[31:0];
				end
			end
		end
		// master capture uses the previous sample, removal clears the offset
		for (int e = 0; e < NMST; e++) begin
			if (clr_m[e]) begin
				n.m_on[e] = 1'b0;
				n.m_off[e] = 32'h0;
			end
			if (set_m[e] && s.last_ok) begin
				n.m_off[e] = s.m_val[e] - s.last[s.m_src[e]];
				n.m_on[e] = 1'b1;
			end else if (set_m[e]) begin
				n.refused = 1'b1;
			end
		end
		// statistics reset wins over an update in the same cycle
		for (int k = 0; k < NSTAT; k++) begin
			if (st_rst[k]) begin
				n.st_empty[k] = 1'b1;
				n.st_cnt[k] = 14'h0;
				n.st_min[k] = 32'h0;
				n.st_max[k] = 32'h0;
			end
		end
		// serial sequencer walks words in source order
		if (s.sq == MPP_SQ_SEND && (!s.ser_mask[s.w_idx] || tx_go)) begin
			if (!s.ser_mask[s.w_idx] || s.b_idx == 2'h2) begin
				n.b_idx = 2'h0;
				if (s.w_idx == SW'(NSRC-1))
					n.sq = MPP_SQ_IDLE;
				else
					n.w_idx = s.w_idx + SW'(1);
			end else begin
				n.b_idx = s.b_idx + 2'h1;
			end
		end
	end
	// state register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.red_n <= `MPP_RST_REDUCE;
			s.baud <= 16'(`MPP_CLK_HZ / `MPP_BAUD_HZ);
			s.range <= `MPP_RST_RANGE;
			s.st_empty <= '1;
			s.sq <= MPP_SQ_IDLE;
		end else begin
			s <= n;
		end
	end
	////////////////////////////////////////////////////////////////////
	// assertions and covers
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	a_master_capture: assert property (set_m[0] && s.last_ok |=>
		s.m_on[0] && s.m_off[0] == $past(s.m_val[0]) -
		$past(s.last[s.m_src[0]])) else $error("master capture wrong");
	a_master_range: assert property (wr && paddr == `MPP_OFF_MVAL &&
		$signed(pwdata) > $signed(`MPP_MST_MAX) |=> s.range_err &&
		$stable(s.m_val)) else $error("out of range master taken");
	a_master_refuse: assert property (set_m[0] && !clr_m[0] &&
		!s.last_ok |=> $stable(s.m_off[0]) && s.refused)
		else $error("master set without target");
	a_master_undo: assert property (clr_m[0] && !set_m[0] |=>
		!s.m_on[0] && s.m_off[0] == 32'h0) else $error("undo failed");
	a_stat_order: assert property (!s.st_empty[0] |->
		$signed(s.st_min[0]) <= $signed(s.st_max[0]))
		else $error("stat min above max");
	a_stat_reset: assert property (st_rst[0] |=> s.st_empty[0] &&
		s.st_cnt[0] == 14'h0) else $error("stat reset ignored");
	a_reduce_cnt: assert property (s.red_cnt < s.red_n)
		else $error("reduction counter overran");
	a_hold_limit: assert property (do_ana &&
		mode == MPP_HOLD_CNT && bad && s.hold_n != 11'h0 &&
		s.held >= s.hold_n |=> s.ana == `MPP_ANA_ERR)
		else $error("hold limit missed");
	a_ana_error: assert property (do_ana && err |=>
		s.ana == `MPP_ANA_ERR) else $error("analog error code missing");
	a_ser_bytes: assert property (tx_go && s.b_idx == 2'h0 |->
		s.sq == MPP_SQ_SEND ##1 s.b_idx == 2'h1)
		else $error("serial byte order broken");
	c_master_set: cover property (set_m[0] && s.last_ok);
	c_stat_wrap: cover property (sample_strobe && s.st_len[0] != 4'h0
		&& s.st_cnt[0] == 14'h1 << s.st_len[0]);
	c_ser_frame: cover property (s.sq == MPP_SQ_SEND ##1
		s.sq == MPP_SQ_IDLE);
	c_ana_div: cover property (div_done);
endmodule

// >>> verif/mpp_host_model.sv
// serial receiving host model: 8N1 byte capture into a queue
`timescale 1ns/1ps
module mpp_host_model (
	input  wire logic        sys_clk,
	input  wire logic        ser_txd,
	input  wire logic [15:0] bit_cyc
);
	logic [7:0] rxq[$];

	// sample mid-bit, lsb first, after start edge
	initial begin
		logic [7:0] b;
		forever begin
			@(negedge ser_txd);
			repeat (bit_cyc / 2) @(posedge sys_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (bit_cyc) @(posedge sys_clk);
				b[i] = ser_txd;
			end
			repeat (bit_cyc) @(posedge sys_clk);
			rxq.push_back(b);
		end
	end
endmodule

// >>> verif/mpp_post_proc_bench.sv
// testbench of the measurement post-processing block
`timescale 1ns/1ps
module mpp_post_proc_bench;
	logic         sys_clk = 0;
	logic         resetn = 0;
	logic [7:0]   paddr = 8'h00;
	logic         psel = 0, penable = 0, pwrite = 0;
	logic [31:0]  pwdata = 32'h0, prdata, r;
	logic         pready, pslverr, perr, ser_txd;
	logic         sample_strobe = 0, sample_ok = 0;
	logic [127:0] sample_data = 128'h0;
	logic [1:0]   mf_in = 2'h0, ana_range;
	logic [15:0]  ana_code;
	int           error_cnt = 0, n_compared = 0;

	mpp_post_proc dut_u (.sys_clk(sys_clk), .resetn(resetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sample_strobe(sample_strobe),
		.sample_data(sample_data), .sample_ok(sample_ok),
		.multifunction_input(mf_in), .ser_txd(ser_txd),
		.ana_code(ana_code), .ana_range(ana_range));
	mpp_host_model host_u (.sys_clk(sys_clk), .ser_txd(ser_txd),
		.bit_cyc(16'h4));

	initial forever #12.5 sys_clk = ~sys_clk;

	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// one apb transfer, held until pready is seen high
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		psel <= 1; paddr <= a; pwrite <= w; pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		r = prdata;
		perr = pslverr;
		psel <= 0; penable <= 0;
		@(posedge sys_clk);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(a, 0, 32'h0);
		chk(r, e);
	endtask

	task send(input logic [31:0] v, input logic ok);
		sample_data <= {96'h0, v}; sample_ok <= ok; sample_strobe <= 1;
		@(posedge sys_clk);
		sample_strobe <= 0;
		@(posedge sys_clk);
	endtask

	// three serial bytes then the analog code
	task out(input logic [17:0] c, input logic [15:0] a);
		int k;
		k = 0;
		while (host_u.rxq.size() < 3 && k < 2000) begin
			@(posedge sys_clk);
			k++;
		end
		repeat (10) @(posedge sys_clk);
		chk(host_u.rxq.size(), 3);
		chk(host_u.rxq.pop_front(), {2'b00, c[5:0]});
		chk(host_u.rxq.pop_front(), {2'b01, c[11:6]});
		chk(host_u.rxq.pop_front(), {2'b10, c[17:12]});
		chk(ana_code, a);
	endtask

	task print_verdict;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		print_verdict;
	end

	initial begin
		repeat (16) @(posedge sys_clk);
		resetn <= 1;
		@(posedge sys_clk);
		chk({ser_txd, ana_code}, 17'h10000);
		rd(8'h04, 32'h1);
		rd(8'h10, 32'h15b);
		rd(8'h20, 32'h000f4240);
		rd(8'h80, 32'h0);
		chk(perr, 1'b1);
		apb(8'h10, 1, 32'h4);
		apb(8'h0c, 1, 32'h1);
		send(32'h3e8, 1);
		out(18'h3e8, 16'h41);
		apb(8'h24, 1, 32'h0);
		apb(8'h28, 1, 32'h0);
		apb(8'h2c, 1, 32'h1);
		send(32'h3e8, 1);
		out(18'h0, 16'h0);
		apb(8'h28, 1, 32'h1388);
		apb(8'h2c, 1, 32'h1);
		send(32'h4b0, 1);
		out(18'h1450, 16'h154);
		apb(8'h28, 1, 32'h7ff89ec1);
		apb(8'h34, 0, 32'h0);
		chk(r[17], 1'b1);
		rd(8'h28, 32'h1388);
		apb(8'h2c, 1, 32'h2);
		send(32'h4b0, 1);
		out(18'h4b0, 16'h4e);
		send(32'h0, 0);
		out(18'h3ffff, 16'h0);
		apb(8'h00, 1, 32'h1);
		send(32'h2bc, 1);
		out(18'h2bc, 16'h2d);
		send(32'h0, 0);
		out(18'h2bc, 16'h2d);
		apb(8'h2c, 1, 32'h1);
		rd(8'h34, 32'h30000);
		apb(8'h08, 1, 32'h1);
		apb(8'h00, 1, 32'h2);
		send(32'h2bc, 1);
		out(18'h2bc, 16'h2d);
		send(32'h0, 0);
		out(18'h2bc, 16'h2d);
		send(32'h0, 0);
		out(18'h3ffff, 16'h0);
		apb(8'h18, 1, 32'h7d0);
		apb(8'h1c, 1, 32'h3e8);
		apb(8'h00, 1, 32'h24);
		send(32'h4b0, 1);
		out(18'h4b0, 16'hcccc);
		chk(ana_range, 2'h1);
		apb(8'h04, 1, 32'h2);
		apb(8'h00, 1, 32'h8);
		send(32'h64, 1);
		repeat (60) @(posedge sys_clk);
		send(32'hc8, 1);
		out(18'hc8, 16'hd);
		apb(8'h00, 1, 32'h0);
		apb(8'h24, 1, 32'h10000);
		mf_in <= 2'h1;
		repeat (2100) @(posedge sys_clk);
		mf_in <= 2'h0;
		rd(8'h34, 32'h70001);
		mf_in <= 2'h2;
		repeat (2100) @(posedge sys_clk);
		mf_in <= 2'h0;
		rd(8'h34, 32'h70000);
		apb(8'h0c, 1, 32'h0);
		apb(8'h2c, 1, 32'h40);
		send(32'h12c, 1);
		send(32'h384, 1);
		repeat (4) @(posedge sys_clk);
		rd(8'h40, 32'h12c);
		rd(8'h44, 32'h384);
		rd(8'h48, 32'h258);
		print_verdict;
	end
endmodule
